// [hw/rxl_exec.sv]
`timescale 1ns/100ps
`default_nettype none
module rxl_exec (
  input wire logic clk,                       // Clock
  input wire logic resetn,                    // Async reset, low
  input wire logic start,                     // Start instruction
  input wire rxl_pkg::rxl_word_t instr,       // Instruction word
  output logic busy,                          // Instruction in progress
  output logic done,                          // Instruction completed
  output logic branch_taken,                  // Completed one branched
  output rxl_pkg::rxl_word_t oper,            // Operation register
  output rxl_pkg::rxl_word_t instr_addr,      // Instruction address
  output rxl_pkg::rxl_word_t last_addr,       // Last instruction address
  output logic [1:0] carry_zero,              // Carry and zero flags
  output logic mem_req,                       // Storage request
  output logic mem_we,                        // Storage write
  output logic [3:0] mem_be,                  // Byte enables
  output rxl_pkg::rxl_word_t mem_addr,        // Storage address
  output rxl_pkg::rxl_word_t mem_wdata,       // Storage write data
  input wire rxl_pkg::rxl_word_t mem_rdata,   // Storage read data
  input wire logic mem_ack,                   // Storage answer
  input wire logic setup_we,                  // Preset local store
  input wire logic [6:0] setup_addr,          // Preset location
  input wire rxl_pkg::rxl_word_t setup_data,  // Preset value
  input wire logic [6:0] peek_addr,           // Local store view address
  output rxl_pkg::rxl_word_t peek_data,       // Local store view data
  input wire rxl_pkg::rxl_wsel_t peek_sel,    // Work register view select
  output rxl_pkg::rxl_word_t peek_work        // Work register view data
);
  import rxl_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_MEM} rxl_state_t;
  rxl_state_t state;       // Sequencer state
  rxl_state_t next_state;  // Next sequencer state
  rxl_word_t work [WORK_N];     // Work registers
  rxl_word_t lstore [LSTORE_N]; // Local store
  rxl_alu_if alu_bus();         // Operand path

  // Field views
  wire [3:0] opc = oper[OPC_HI:OPC_LO];
  wire rxl_wsel_t fa = oper[FA_HI:FA_LO];
  wire rxl_wsel_t fb = oper[FB_HI:FB_LO];
  wire [15:0] disp = oper[DISP_HI:DISP_LO];
  // Decode
  wire is_xor = opc == OP_XOR;
  wire is_loadh = opc == OP_LOADH;
  wire is_store = (opc == OP_STOREH) | (opc == OP_STOREW);
  wire take_branch = (is_xor | is_loadh) & alu_bus.first_zero;
  wire need_mem = is_store | (is_loadh & ~alu_bus.first_zero);
  wire finish = ((state == S_EXEC) & ~need_mem) | ((state == S_MEM) & mem_ack);
  wire wr_en = finish & ~take_branch & (is_xor | is_loadh);
  wire rxl_word_t wr_val = is_xor ? alu_bus.xor_res : {16'h0000, mem_rdata[15:0]};
  wire setup_ok = setup_we & (state == S_IDLE);
  wire start_ok = start & (state == S_IDLE);
  wire rxl_word_t xor_check = work[fa] ^ work[fb];

  // ----------------------------------------------------------------------
  // Datapath hookup
  // ----------------------------------------------------------------------
  assign alu_bus.oper = oper;
  assign alu_bus.work_a = work[fa];
  assign alu_bus.work_b = work[fb];
  assign alu_bus.lstore_base = lstore[LSTORE_BASE_LOC];
  assign alu_bus.lstore_src = lstore[LSTORE_SRC_LOC];

  rxl_alu u_alu (
    .alu_bus(alu_bus)
  );

  assign busy = state != S_IDLE;
  assign mem_req = state == S_MEM;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Next state selection
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE: if (start) next_state = S_EXEC;
      S_EXEC: next_state = need_mem ? S_MEM : S_IDLE;
      S_MEM: if (mem_ack) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) state <= S_IDLE;
    else state <= next_state;
  end

  // Operation register loads only when idle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) oper <= WORK_RST;
    else if (start_ok) oper <= instr;
  end

  // ----------------------------------------------------------------------
  // Work registers and local store
  // ----------------------------------------------------------------------
  // Work registers 1 to 7 take results; each work register takes presets
  for (genvar i = 0; i < WORK_N; i++)
  begin : g_work
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn) work[i] <= WORK_RST;
      else if (wr_en && fa == rxl_wsel_t'(i)) work[i] <= wr_val;
      else if (setup_ok && setup_addr == 7'(i)) work[i] <= setup_data;
    end
  end

  // Local store mirrors each result at the register's location
  always_ff @(posedge clk)
  begin
    if (wr_en) lstore[{4'h0, fa}] <= wr_val;
    else if (setup_ok) lstore[setup_addr] <= setup_data;
  end

  // Flags follow written results; stores never touch them
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) carry_zero <= 2'h0;
    else if (wr_en)
    begin
      carry_zero[CFLAG_CARRY] <= 1'b0;
      carry_zero[CFLAG_ZERO] <= wr_val == 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction addresses and completion
  // ----------------------------------------------------------------------
  // Step or branch, and remember the finished address
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      instr_addr <= INSTR_ADDR_RST;
      last_addr <= INSTR_ADDR_RST;
    end
    else if (finish)
    begin
      instr_addr <= take_branch ? alu_bus.eff_addr : instr_addr + INSTR_STEP;
      last_addr <= instr_addr;
    end
  end

  // Completion pulse, one cycle after the last step
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      done <= 1'b0;
      branch_taken <= 1'b0;
    end
    else
    begin
      done <= finish;
      branch_taken <= finish & take_branch;
    end
  end

  // ----------------------------------------------------------------------
  // Storage side
  // ----------------------------------------------------------------------
  // Address and data held for the whole request
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_addr <= WORK_RST;
      mem_wdata <= WORK_RST;
      mem_be <= 4'h0;
      mem_we <= 1'b0;
    end
    else if (state == S_EXEC && need_mem)
    begin
      mem_addr <= alu_bus.eff_addr;
      mem_wdata <= alu_bus.store_data;
      mem_be <= is_store ? alu_bus.store_be : BE_HALF;
      mem_we <= is_store;
    end
  end

  // Observation ports
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      peek_data <= WORK_RST;
      peek_work <= WORK_RST;
    end
    else
    begin
      peek_data <= lstore[peek_addr];
      peek_work <= work[peek_sel];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_oper_hold;
    busy |=> $stable(oper);
  endproperty
  a_oper_hold: assert property (p_oper_hold) else $error("operation register changed mid instruction");

  property p_step;
    done && !branch_taken |-> instr_addr == last_addr + INSTR_STEP;
  endproperty
  a_step: assert property (p_step) else $error("instruction address did not step");

  property p_branch;
    done && branch_taken |-> instr_addr == ({16'h0000, disp} + (fb == 3'h0 ? lstore[LSTORE_BASE_LOC] : work[fb]));
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");

  property p_mirror;
    done && $past(wr_en) |-> lstore[{4'h0, fa}] == work[fa] && carry_zero[CFLAG_ZERO] == (work[fa] == 32'h0);
  endproperty
  a_mirror: assert property (p_mirror) else $error("result not mirrored or flags wrong");

  property p_flags_keep;
    finish && is_store |=> $stable(carry_zero);
  endproperty
  a_flags_keep: assert property (p_flags_keep) else $error("store changed flags");

  property p_xor;
    state == S_EXEC && is_xor && !take_branch |=> work[fa] == $past(xor_check);
  endproperty
  a_xor: assert property (p_xor) else $error("exclusive OR result wrong");

  property p_store_addr;
    mem_req && mem_we |-> mem_addr == ({16'h0000, disp} + (fb == 3'h0 ? lstore[LSTORE_BASE_LOC] : work[fb]));
  endproperty
  a_store_addr: assert property (p_store_addr) else $error("store address wrong");

  property p_store_data;
    mem_req && mem_we && opc == OP_STOREW |-> mem_wdata == (fa == 3'h0 ? lstore[LSTORE_SRC_LOC] : work[fa]);
  endproperty
  a_store_data: assert property (p_store_data) else $error("store data wrong");
endmodule // rxl_exec
`default_nettype wire

// [hw/rxl_pkg.sv]
// ----------------------------------------------------------------------
// Shared constants for the execution unit
// ----------------------------------------------------------------------
package rxl_pkg;
  // Sizes
  localparam int WORK_N = 8;               // Work registers
  localparam int LSTORE_N = 128;           // Local store words
  // Instruction field positions
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 28;
  localparam int FA_HI = 26;               // Destination / source field
  localparam int FA_LO = 24;
  localparam int FB_HI = 22;               // Second operand / base field
  localparam int FB_LO = 20;
  localparam int DISP_HI = 15;             // Displacement field
  localparam int DISP_LO = 0;
  // Operation codes
  localparam logic [3:0] OP_XOR = 4'h1;    // register_exclusive_or
  localparam logic [3:0] OP_LOADH = 4'h2;  // load_halfword
  localparam logic [3:0] OP_STOREH = 4'h3; // store_halfword
  localparam logic [3:0] OP_STOREW = 4'h4; // full_word_write
  // Fixed local store locations
  localparam logic [6:0] LSTORE_BASE_LOC = 7'h45;
  localparam logic [6:0] LSTORE_SRC_LOC = 7'h68;
  // Address step and reset values
  localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
  localparam logic [31:0] INSTR_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] WORK_RST = 32'h0000_0000;
  // Byte enables
  localparam logic [3:0] BE_HALF = 4'h3;
  localparam logic [3:0] BE_FULL = 4'hF;
  // Flag bit positions
  localparam int CFLAG_CARRY = 1;
  localparam int CFLAG_ZERO = 0;
  // Types
  typedef logic [31:0] rxl_word_t;
  typedef logic [2:0] rxl_wsel_t;
endpackage

// [hw/rxl_alu_if.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Operand path between sequencer and datapath
// ----------------------------------------------------------------------
interface rxl_alu_if;
  import rxl_pkg::*;
  rxl_word_t oper;        // Current instruction
  rxl_word_t work_a;      // Work register named by first field
  rxl_word_t work_b;      // Work register named by second field
  rxl_word_t lstore_base; // Fixed base word
  rxl_word_t lstore_src;  // Fixed source word
  rxl_word_t xor_res;     // Exclusive OR result
  rxl_word_t eff_addr;    // Storage address
  rxl_word_t store_data;  // Data to write
  logic [3:0] store_be;   // Byte enables for write
  logic first_zero;       // First field is zero
  logic second_zero;      // Second field is zero
  modport exec (output oper, work_a, work_b, lstore_base, lstore_src,
                input xor_res, eff_addr, store_data, store_be, first_zero, second_zero);
  modport alu (input oper, work_a, work_b, lstore_base, lstore_src,
               output xor_res, eff_addr, store_data, store_be, first_zero, second_zero);
endinterface
`default_nettype wire

// [hw/rxl_alu.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Datapath: result, address and store data
// ----------------------------------------------------------------------
module rxl_alu (
  rxl_alu_if.alu alu_bus // Operand path
);
  import rxl_pkg::*;

  // Field views of the instruction
  wire [3:0] opc = alu_bus.oper[OPC_HI:OPC_LO];
  wire rxl_wsel_t fa = alu_bus.oper[FA_HI:FA_LO];
  wire rxl_wsel_t fb = alu_bus.oper[FB_HI:FB_LO];
  wire [15:0] disp = alu_bus.oper[DISP_HI:DISP_LO];
  // Selected base and source words
  wire rxl_word_t base_val;
  wire rxl_word_t src_val;

  assign alu_bus.first_zero = fa == 3'h0;
  assign alu_bus.second_zero = fb == 3'h0;
  // Bitwise exclusive OR of the two work registers
  assign alu_bus.xor_res = alu_bus.work_a ^ alu_bus.work_b;
  // Base register, or fixed word when base field is zero
  assign base_val = alu_bus.second_zero ? alu_bus.lstore_base : alu_bus.work_b;
  assign alu_bus.eff_addr = base_val + {16'h0000, disp};
  // Source register, or fixed word when source field is zero
  assign src_val = alu_bus.first_zero ? alu_bus.lstore_src : alu_bus.work_a;
  // Halfword writes carry the low half only
  assign alu_bus.store_data = (opc == OP_STOREH) ? {16'h0000, src_val[15:0]} : src_val;
  assign alu_bus.store_be = (opc == OP_STOREH) ? BE_HALF : BE_FULL;
endmodule // rxl_alu
`default_nettype wire

// [dv/rxl_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Main storage stand-in: answers each request after a chosen wait
// ----------------------------------------------------------------------
module rxl_mem_model (
  input wire logic clk,                     // Clock
  input wire logic resetn,                  // Async reset, low
  input wire logic [3:0] lat,               // Wait cycles before answer
  input wire logic mem_req,                 // Storage request
  input wire logic mem_we,                  // Write when high
  input wire logic [3:0] mem_be,            // Byte enables
  input wire rxl_pkg::rxl_word_t mem_addr,  // Storage address
  input wire rxl_pkg::rxl_word_t mem_wdata, // Write data
  output rxl_pkg::rxl_word_t mem_rdata,     // Read data
  output logic mem_ack,                     // Answer pulse
  output rxl_pkg::rxl_word_t seen_addr,     // Address of last request
  output rxl_pkg::rxl_word_t seen_data,     // Data of last request
  output logic [3:0] seen_be,               // Enables of last request
  output int req_count                      // Requests answered
);
  import rxl_pkg::*;
  logic [3:0] wait_cnt; // Cycles waited so far
  // Wait, answer once, record the request
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      mem_rdata <= 32'h0000_0000;
      req_count <= 0;
    end
    else if (mem_ack || !mem_req)
    begin
      // Released: read data no longer holds its value
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end
    else if (wait_cnt < lat)
    begin
      // Stall
      wait_cnt <= wait_cnt + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
    else
    begin
      // Answer; read data is a pattern of the address
      mem_ack <= 1'b1;
      mem_rdata <= {16'hFFFF, mem_addr[15:0] ^ 16'h5A5A};
      seen_addr <= mem_addr;
      seen_data <= mem_wdata;
      seen_be <= mem_be;
      req_count <= req_count + 1;
    end
  end
endmodule // rxl_mem_model
`default_nettype wire

// [dv/tb_regxor_load_store_execute.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Self-checking bench for the execution unit
// ----------------------------------------------------------------------
module tb_regxor_load_store_execute;
  import rxl_pkg::*;
  // One instruction and what it should leave behind
  typedef struct {
    rxl_word_t instr; // Instruction
    rxl_word_t val;   // Result, store data or branch target
    rxl_word_t addr;  // Storage address
    logic [1:0] cz;   // Flags afterwards
  } rxl_row_t;
  logic clk, resetn, start, busy, done, branch_taken, mem_req, mem_we, mem_ack, setup_we;
  rxl_word_t instr, oper, instr_addr, last_addr, mem_addr, mem_wdata, mem_rdata, setup_data;
  rxl_word_t peek_data, peek_work, seen_addr, seen_data, ia, la;
  logic [1:0] carry_zero; // Flags seen
  logic [3:0] mem_be, seen_be, lat;
  logic [6:0] setup_addr, peek_addr;
  rxl_wsel_t peek_sel; // Work register to view
  int err_total, samples_checked, req_count, req_exp;
  rxl_row_t rows [13]; // Ordinary cases, run in order
  rxl_exec rxl_exec_inst (.clk(clk), .resetn(resetn), .start(start), .instr(instr), .busy(busy),
    .done(done), .branch_taken(branch_taken), .oper(oper), .instr_addr(instr_addr),
    .last_addr(last_addr), .carry_zero(carry_zero), .mem_req(mem_req), .mem_we(mem_we),
    .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .setup_we(setup_we), .setup_addr(setup_addr), .setup_data(setup_data),
    .peek_addr(peek_addr), .peek_data(peek_data), .peek_sel(peek_sel), .peek_work(peek_work));
  rxl_mem_model rxl_mem_model_inst (.clk(clk), .resetn(resetn), .lat(lat), .mem_req(mem_req),
    .mem_we(mem_we), .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .seen_addr(seen_addr), .seen_data(seen_data),
    .seen_be(seen_be), .req_count(req_count));
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string what, input rxl_word_t exp, input rxl_word_t got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Preset a local store word (and work register below 8)
  // Strobe stays high between presets; the caller lowers it after the last
  task automatic preset(input logic [6:0] a, input rxl_word_t d);
    setup_we = 1'b1;
    setup_addr = a;
    setup_data = d;
    @(negedge clk);
  endtask
  // Issue one instruction and wait for completion, bounded
  task automatic run(input rxl_word_t ins);
    int n = 0;
    start = 1'b1;
    instr = ins;
    @(negedge clk);
    start = 1'b0;
    while (done !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    chk("done", 32'h1, {31'h0, done});
  endtask
  // Run one row and check every visible effect
  task automatic do_row(input rxl_row_t r);
    logic [3:0] op;
    logic br;
    logic st;
    rxl_word_t m;
    op = r.instr[31:28];
    br = (op == OP_XOR || op == OP_LOADH) && r.instr[26:24] == 3'h0;
    st = (op == OP_STOREH || op == OP_STOREW);
    m = (op == OP_STOREH) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    // Every finish, branch included, records the address just left
    la = ia;
    ia = br ? r.val : ia + INSTR_STEP;
    if ((op == OP_LOADH || st) && !br)
      req_exp++;
    run(r.instr);
    chk("oper", r.instr, oper);
    chk("branch", {31'h0, br}, {31'h0, branch_taken});
    chk("iar", ia, instr_addr);
    chk("lar", la, last_addr);
    chk("flags", {30'h0, r.cz}, {30'h0, carry_zero});
    chk("reqs", req_exp, req_count);
    if ((op == OP_LOADH || st) && !br)
    begin
      chk("addr", r.addr, seen_addr);
      chk("we", {31'h0, st}, {31'h0, mem_we});
    end
    if (st)
    begin
      chk("data", r.val & m, seen_data & m);
      chk("be", {28'h0, m[31] ? BE_FULL : BE_HALF}, {28'h0, seen_be});
    end
    if ((op == OP_XOR || op == OP_LOADH) && !br)
    begin
      // View the destination one cycle later
      peek_sel = r.instr[26:24];
      peek_addr = {4'h0, r.instr[26:24]};
      @(negedge clk);
      chk("work", r.val, peek_work);
      chk("lstore", r.val, peek_data);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Cut a hang short
  initial
  begin
    #20000;
    err_total++;
    test_done();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {resetn, start, instr, setup_we, setup_addr, setup_data, peek_addr, peek_sel, lat} = '0;
    {err_total, samples_checked, req_exp} = '0;
    {ia, la} = '0;
    rows = '{'{32'h1160_0000, 32'h1234_5778, 32'h0, 2'b00}, '{32'h2450_0010, 32'h584A, 32'h210, 2'b00},
      '{32'h2400_0008, 32'h5D52, 32'h708, 2'b00}, '{32'h1230_0000, 32'h0, 32'h0, 2'b01},
      '{32'h3610_0004, 32'h1234_5678, 32'h1234_577C, 2'b01}, '{32'h3050_0002, 32'hA5A5_1234, 32'h202, 2'b01},
      '{32'h4700_0000, 32'h800, 32'h700, 2'b01}, '{32'h4000_0020, 32'hA5A5_1234, 32'h720, 2'b01},
      '{32'h1070_0040, 32'h840, 32'h0, 2'b01}, '{32'h2000_0010, 32'h710, 32'h0, 2'b01},
      '{32'h3000_0004, 32'hA5A5_1234, 32'h704, 2'b01}, '{32'h4510_007C, 32'h200, 32'h1234_57F4, 2'b01},
      '{32'h5000_0000, 32'h0, 32'h0, 2'b01}};
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    preset(7'h01, 32'h0000_0100);
    preset(7'h02, 32'h0000_0300);
    preset(7'h03, 32'h0000_0300);
    preset(7'h05, 32'h0000_0200);
    preset(7'h06, 32'h1234_5678);
    preset(7'h07, 32'h0000_0800);
    preset(LSTORE_BASE_LOC, 32'h0000_0700);
    preset(LSTORE_SRC_LOC, 32'hA5A5_1234);
    setup_we = 1'b0;
    foreach (rows[i])
      do_row(rows[i]);
    // Slow storage, with a second start while busy
    lat = 4'h6;
    do_row('{32'h4700_0000, 32'h800, 32'h700, 2'b01});
    start = 1'b1;
    instr = 32'h4700_0000;
    @(negedge clk);
    run(32'h1230_0000);
    chk("oper", 32'h4700_0000, oper);
    chk("iar", ia + INSTR_STEP, instr_addr);
    // Reset while storage is pending, then restart from zero
    start = 1'b1;
    instr = 32'h4700_0000;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    resetn = 1'b0;
    @(negedge clk);
    chk("busy", 32'h0, {31'h0, busy});
    chk("req", 32'h0, {31'h0, mem_req});
    chk("iar", 32'h0, instr_addr);
    resetn = 1'b1;
    {ia, la} = '0;
    req_exp = 0;
    do_row('{32'h1230_0000, 32'h0, 32'h0, 2'b01});
    test_done();
  end
endmodule // tb_regxor_load_store_execute
`default_nettype wire
